// ### bdl_ctrl.sv
// Brake, dead-time, lock and burst-access block with AHB-Lite registers
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - An active brake clears the main output enable asynchronously.
// - Main enable set lets both outputs drive; clear forces idle or off.
// - Auto enable lets an update event set main enable, else software only.
// - Brake polarity one means high is active, zero means low is active.
// - Brake enable one honours the brake input, zero ignores it.
// - Brake polarity and enable writes take effect one clock later.
// - Run off-state set: disabled channel drives inactive level, then enable.
// - Idle off-state set: with timer stopped, drive idle level, then enable.
// - Lock one freezes dead time, brake bits, auto enable and idle levels.
// - Lock two also freezes channel polarities and both off-state selects.
// - Lock three also freezes the channel enable bits.
// - Top dead-time bit zero: dead time is the field times one period.
// - Top bits one-zero: dead time is 64 plus low six, times two.
// - Burst count is the length field plus one.
// - Burst base is a word offset from the first control register.
// - The burst access register is the single address for burst transfers.
// - Channel four keeps a read-only level bit beside its captured value.
// - Channel four value is sixteen bits, resets to zero, bits 31 to 17 read zero.
module bdl_ctrl (
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Timer side, same clock
  input  wire logic        I_OC_REF,
  input  wire logic        I_UPDATE,
  input  wire logic        I_CH4_CAPTURE,
  input  wire logic [15:0] I_CH4_CAPT_VAL,
  input  wire logic        I_CH4_LEVEL,
  // Brake pin
  input  wire logic        I_BRAKE,
  // Power stage pins
  output logic             O_CH_OUT,
  output logic             O_CH_OE_N,
  output logic             O_CHN_OUT,
  output logic             O_CHN_OE_N
);
  import bdl_pkg::*;

  typedef struct packed {
    logic              ph_valid;
    logic              ph_write;
    logic [7:0]        ph_addr;
    logic              hready;
    logic [31:0]       hrdata;
    logic              run;
    logic              ois;
    logic              oisn;
    logic              cce;
    logic              ccp;
    logic              ccne;
    logic              ccnp;
    logic [15:0]       compare_value_ch4;
    logic              lvl4;
    logic              auto_output_enable;
    logic              brake_polarity;
    logic              brake_enable;
    logic              bkp_eff;
    logic              bke_eff;
    logic              run_offstate_select;
    logic              idle_offstate_select;
    logic [1:0]        lock;
    logic              lock_done;
    logic [7:0]        deadtime_setting;
    logic [4:0]        blen;
    logic [4:0]        bbase;
    logic [4:0]        bidx;
    logic [31:0]       bacc;
    logic              brk_s1;
    logic              brk_s2;
    logic              ref_prev;
    logic [DT_W-1:0]   dt_cnt;
    logic              drv_m;
    logic              drv_c;
    logic              ch_out;
    logic              ch_oe_n;
    logic              chn_out;
    logic              chn_oe_n;
  } bdl_state_s;

  bdl_state_s st_r;
  bdl_state_s st_nxt;
  logic       moe_r;
  logic       brk_async;
  logic       brk_act;
  logic       sw_set;
  logic       sw_clr;
  logic       upd;
  logic       dt_zero;
  logic       wave_m;
  logic       wave_c;

  // ****************************************
  // Dead-time decode
  // ****************************************
  function automatic logic [DT_W-1:0] dt_len(input logic [7:0] d);
    logic [DT_W-1:0] n;
    n = '0;
    if (!d[7]) begin
      n = DT_W'(d);
    end else if (!d[6]) begin
      n = DT_W'((7'd64 + {1'b0, d[5:0]}) * 2);
    end else if (!d[5]) begin
      n = DT_W'((6'd32 + {1'b0, d[4:0]}) * 8);
    end else begin
      n = DT_W'((6'd32 + {1'b0, d[4:0]}) * 16);
    end
    return DT_W'(n * DTS_CYC);
  endfunction

  // ****************************************
  // Register read mux
  // ****************************************
  function automatic logic [31:0] rd_reg(input bdl_state_s s, input logic main_output_enable,
                                         input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      OFS_CTRL: begin
        v[CTRL_RUN]  = s.run;
        v[CTRL_OIS]  = s.ois;
        v[CTRL_OISN] = s.oisn;
      end
      OFS_CHEN: v[3:0] = {s.ccnp, s.ccne, s.ccp, s.cce};
      OFS_COMPARE_VALUE_CH4: v = {15'h0000, s.lvl4, s.compare_value_ch4};
      OFS_BDTR: v = {16'h0000, main_output_enable, s.auto_output_enable, s.brake_polarity, s.brake_enable, s.run_offstate_select, s.idle_offstate_select,
                     s.lock, s.deadtime_setting};
      OFS_BCFG: v = {19'h00000, s.blen, 3'h0, s.bbase};
      OFS_BACC: v = s.bacc;
      default:  v = '0;
    endcase
    return v;
  endfunction

  // Brake seen through the settings that took effect one clock ago
  assign brk_async = st_r.bke_eff & (I_BRAKE == st_r.bkp_eff);
  assign brk_act   = st_r.bke_eff & (st_r.brk_s2 == st_r.bkp_eff);

  // ****************************************
  // Write decode
  // ****************************************
  logic        wr_go;
  logic        acc_go;
  logic [7:0]  eff_addr;
  logic [5:0]  burst_word;
  assign wr_go      = st_r.ph_valid & st_r.ph_write & st_r.hready;
  assign acc_go     = st_r.ph_valid & (st_r.ph_write ? st_r.hready : !st_r.hready);
  assign burst_word = 6'(st_r.bbase) + 6'(st_r.bidx);
  assign eff_addr   = (st_r.ph_addr == OFS_BACC) ? {burst_word, 2'b00}
                                                 : st_r.ph_addr;
  assign sw_set     = wr_go & (eff_addr == OFS_BDTR) & I_HWDATA[BD_MOE];
  assign sw_clr     = wr_go & (eff_addr == OFS_BDTR) & !I_HWDATA[BD_MOE];
  assign upd        = I_UPDATE | (wr_go & (eff_addr == OFS_CTRL) & I_HWDATA[CTRL_UPD]);

  // ****************************************
  // Main output enable
  // ****************************************
  // Kept apart from the state struct because the brake must clear it
  // without a clock edge; a glitch on the pin can only ever switch off.
  always_ff @(posedge I_CLOCK or posedge I_RST or posedge brk_async) begin
    if (I_RST) begin
      moe_r <= 1'b0;
    end else if (brk_async) begin
      moe_r <= 1'b0;
    end else if (sw_clr) begin
      moe_r <= 1'b0;
    end else if (!brk_act && (sw_set || (st_r.auto_output_enable && upd))) begin
      moe_r <= 1'b1;
    end
  end

  assign dt_zero = (st_r.dt_cnt == '0);
  // The counter reloads only at the edge, so the edge cycle itself is held off
  assign wave_m  = I_OC_REF & (I_OC_REF == st_r.ref_prev) & dt_zero;
  assign wave_c  = !I_OC_REF & (I_OC_REF == st_r.ref_prev) & dt_zero;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic        act;
    logic        dm;
    logic        dc;
    logic        vm;
    logic        vc;
    logic        l1;
    logic        l2;
    logic        l3;
    act    = 1'b0;
    dm     = 1'b0;
    dc     = 1'b0;
    vm     = 1'b0;
    vc     = 1'b0;
    l1     = (st_r.lock != LOCK_OFF);
    l2     = st_r.lock[1];
    l3     = (st_r.lock == LOCK_L3);
    st_nxt = st_r;

    // Bus: writes need no wait, reads take one wait state
    if (acc_go && !st_r.ph_write) begin
      st_nxt.hrdata   = (eff_addr == OFS_BACC) ? st_r.bacc : rd_reg(st_r, moe_r, eff_addr);
      st_nxt.hready   = 1'b1;
      st_nxt.ph_valid = 1'b0;
    end else if (st_r.hready) begin
      st_nxt.ph_valid = I_HSEL & I_HTRANS[1] & I_HREADY;
      st_nxt.ph_write = I_HWRITE;
      st_nxt.ph_addr  = I_HADDR[7:0];
      if (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE) begin
        st_nxt.hready = 1'b0;
      end
    end
    if (acc_go && (st_r.ph_addr == OFS_BACC)) begin
      st_nxt.bidx = (st_r.bidx == st_r.blen) ? 5'h00 : st_r.bidx + 5'h01;
    end

    if (wr_go) begin
      case (eff_addr)
        OFS_CTRL: begin
          st_nxt.run = I_HWDATA[CTRL_RUN];
          if (!l1) begin
            st_nxt.ois  = I_HWDATA[CTRL_OIS];
            st_nxt.oisn = I_HWDATA[CTRL_OISN];
          end
        end
        OFS_CHEN: begin
          if (!l3) begin
            st_nxt.cce  = I_HWDATA[CHEN_CCE];
            st_nxt.ccne = I_HWDATA[CHEN_CCNE];
          end
          if (!l2) begin
            st_nxt.ccp  = I_HWDATA[CHEN_CCP];
            st_nxt.ccnp = I_HWDATA[CHEN_CCNP];
          end
        end
        OFS_COMPARE_VALUE_CH4: st_nxt.compare_value_ch4 = I_HWDATA[15:0];
        OFS_BDTR: begin
          if (!l1) begin
            st_nxt.auto_output_enable = I_HWDATA[BD_AOE];
            st_nxt.brake_polarity = I_HWDATA[BD_BKP];
            st_nxt.brake_enable = I_HWDATA[BD_BKE];
            st_nxt.deadtime_setting = I_HWDATA[BD_DTG +: 8];
          end
          if (!l2) begin
            st_nxt.run_offstate_select = I_HWDATA[BD_RUN_OFFSTATE_SELECT];
            st_nxt.idle_offstate_select = I_HWDATA[BD_IDLE_OFFSTATE_SELECT];
          end
          if (!st_r.lock_done) begin
            st_nxt.lock      = I_HWDATA[BD_LOCK +: 2];
            st_nxt.lock_done = 1'b1;
          end
        end
        OFS_BCFG: begin
          st_nxt.blen  = I_HWDATA[BC_LEN +: 5];
          st_nxt.bbase = I_HWDATA[BC_BASE +: 5];
        end
        OFS_BACC: st_nxt.bacc = I_HWDATA;
        default: begin
        end
      endcase
    end

    // Capture beats a software write in the same cycle
    if (I_CH4_CAPTURE) begin
      st_nxt.compare_value_ch4 = I_CH4_CAPT_VAL;
      st_nxt.lvl4 = I_CH4_LEVEL;
    end

    st_nxt.bkp_eff = st_r.brake_polarity;
    st_nxt.bke_eff = st_r.brake_enable;
    st_nxt.brk_s1  = I_BRAKE;
    st_nxt.brk_s2  = st_r.brk_s1;

    // Dead-time counter restarts on every reference edge
    st_nxt.ref_prev = I_OC_REF;
    if (I_OC_REF != st_r.ref_prev) begin
      st_nxt.dt_cnt = dt_len(st_r.deadtime_setting);
    end else if (!dt_zero) begin
      st_nxt.dt_cnt = st_r.dt_cnt - DT_W'(1);
    end

    // Output stage
    act = moe_r & st_r.run;
    if (act) begin
      dm = st_r.cce | st_r.run_offstate_select;
      dc = st_r.ccne | st_r.run_offstate_select;
      vm = st_r.cce ? (wave_m ^ st_r.ccp) : st_r.ccp;
      vc = st_r.ccne ? (wave_c ^ st_r.ccnp) : st_r.ccnp;
    end else begin
      dm = st_r.cce & st_r.idle_offstate_select;
      dc = st_r.ccne & st_r.idle_offstate_select;
      vm = st_r.ois;
      vc = st_r.oisn;
    end
    st_nxt.drv_m    = dm;
    st_nxt.drv_c    = dc;
    st_nxt.ch_out   = dm & vm;
    st_nxt.chn_out  = dc & vc;
    // Level goes out one cycle before the driver turns on
    st_nxt.ch_oe_n  = !(dm & st_r.drv_m);
    st_nxt.chn_oe_n = !(dc & st_r.drv_c);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      st_r          <= '0;
      st_r.hready   <= 1'b1;
      st_r.compare_value_ch4     <= COMPARE_VALUE_CH4_RST;
      st_r.bacc     <= BACC_RST;
      st_r.lock     <= LOCK_OFF;
      st_r.ch_oe_n  <= 1'b1;
      st_r.chn_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_HRDATA    = st_r.hrdata;
  assign O_HREADYOUT = st_r.hready;
  assign O_HRESP     = 1'b0;
  assign O_CH_OUT    = st_r.ch_out;
  assign O_CH_OE_N   = st_r.ch_oe_n;
  assign O_CHN_OUT   = st_r.chn_out;
  assign O_CHN_OE_N  = st_r.chn_oe_n;

  // ****************************************
  // Assertions
  // ****************************************
  property p_brake_moe;
    @(posedge I_CLOCK) disable iff (I_RST) brk_act |-> !moe_r;
  endproperty
  a_brake_moe: assert property (p_brake_moe) else $error("brake left main enable set");

  property p_moe_off;
    @(posedge I_CLOCK) disable iff (I_RST)
      (!moe_r && !st_r.idle_offstate_select) |=> (O_CH_OE_N && O_CHN_OE_N);
  endproperty
  a_moe_off: assert property (p_moe_off) else $error("output driven with main enable clear");

  property p_auto_set;
    @(posedge I_CLOCK) disable iff (I_RST)
      (upd && st_r.auto_output_enable && !brk_act && !brk_async && !sw_clr) |=> (moe_r || brk_act);
  endproperty
  a_auto_set: assert property (p_auto_set) else $error("update did not set main enable");

  property p_sw_only;
    @(posedge I_CLOCK) disable iff (I_RST) (!st_r.auto_output_enable && !sw_set && !moe_r) |=> !moe_r;
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("main enable set without software");

  property p_brk_delay;
    @(posedge I_CLOCK) disable iff (I_RST)
      $changed(st_r.brake_polarity) |-> (st_r.bkp_eff != st_r.brake_polarity) ##1 (st_r.bkp_eff == st_r.brake_polarity);
  endproperty
  a_brk_delay: assert property (p_brk_delay) else $error("brake polarity delay wrong");

  property p_lock1;
    @(posedge I_CLOCK) disable iff (I_RST)
      (st_r.lock != LOCK_OFF) |=> ($stable(st_r.deadtime_setting) && $stable(st_r.brake_enable) && $stable(st_r.ois));
  endproperty
  a_lock1: assert property (p_lock1) else $error("level one field changed");

  property p_lock2;
    @(posedge I_CLOCK) disable iff (I_RST)
      st_r.lock[1] |=> ($stable(st_r.run_offstate_select) && $stable(st_r.ccp));
  endproperty
  a_lock2: assert property (p_lock2) else $error("level two field changed");

  property p_lock3;
    @(posedge I_CLOCK) disable iff (I_RST)
      (st_r.lock == LOCK_L3) |=> ($stable(st_r.cce) && $stable(st_r.ccne));
  endproperty
  a_lock3: assert property (p_lock3) else $error("level three field changed");

  property p_lock_once;
    @(posedge I_CLOCK) disable iff (I_RST) st_r.lock_done |=> $stable(st_r.lock);
  endproperty
  a_lock_once: assert property (p_lock_once) else $error("lock field written twice");

  sequence s_ref_rise;
    $rose(I_OC_REF) ##1 (st_r.dt_cnt != '0);
  endsequence
  property p_dead;
    @(posedge I_CLOCK) disable iff (I_RST) s_ref_rise |-> !wave_m && !wave_c;
  endproperty
  a_dead: assert property (p_dead) else $error("output rose inside dead time");

  property p_dead_edge;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_OC_REF != st_r.ref_prev) |-> (!wave_m && !wave_c);
  endproperty
  a_dead_edge: assert property (p_dead_edge) else $error("output rose on a reference edge");

  property p_dt_load;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_OC_REF != st_r.ref_prev) && (st_r.deadtime_setting == 8'hC1) |=> (st_r.dt_cnt == DT_W'(264));
  endproperty
  a_dt_load: assert property (p_dt_load) else $error("dead time count wrong");

  property p_burst_wrap;
    @(posedge I_CLOCK) disable iff (I_RST)
      (acc_go && st_r.ph_addr == OFS_BACC && st_r.bidx == st_r.blen) |=> (st_r.bidx == 5'h00);
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst index did not wrap");

  property p_level;
    @(posedge I_CLOCK) disable iff (I_RST)
      I_CH4_CAPTURE |=> (st_r.lvl4 == $past(I_CH4_LEVEL));
  endproperty
  a_level: assert property (p_level) else $error("level bit not captured");
endmodule

// ### bdl_ctrl_tb.sv
// Self-checking testbench for the brake, dead-time, lock and burst block
`timescale 1ns/1ps
module bdl_ctrl_tb;
  import bdl_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst, hsel, hwrite, hready_o, hresp, oc_ref, upd, capt, lvl, brk;
  logic        ch, ch_oe_n, chn, chn_oe_n, hi_gate, lo_gate, shoot;
  logic [31:0] haddr, hwdata, hrdata, rd, a;
  logic [1:0]  htrans;
  logic [15:0] cval;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [7:0]  offs [5] = '{OFS_COMPARE_VALUE_CH4, OFS_BDTR, OFS_BCFG, OFS_BACC, 8'h80};
  logic [2:0]  tops [4] = '{3'b000, 3'b100, 3'b110, 3'b111};

  bdl_ctrl i_bdl_ctrl (.I_CLOCK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready_o), .O_HRDATA(hrdata), .O_HREADYOUT(hready_o), .O_HRESP(hresp),
    .I_OC_REF(oc_ref), .I_UPDATE(upd), .I_CH4_CAPTURE(capt), .I_CH4_CAPT_VAL(cval),
    .I_CH4_LEVEL(lvl), .I_BRAKE(brk), .O_CH_OUT(ch), .O_CH_OE_N(ch_oe_n),
    .O_CHN_OUT(chn), .O_CHN_OE_N(chn_oe_n));
  bdl_stage i_bdl_stage (.i_clk(clk), .i_rst(rst), .i_hi(ch), .i_hi_oe_n(ch_oe_n),
    .i_lo(chn), .i_lo_oe_n(chn_oe_n), .o_hi_gate(hi_gate), .o_lo_gate(lo_gate),
    .o_shoot(shoot));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Longest run is a few thousand cycles; this only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Select stays high; an idle transfer type marks the bus quiet between calls
  task automatic bus(input logic [7:0] ad, input logic wr_en, input logic [31:0] wd);
    haddr  <= {24'h0, ad};
    hwrite <= wr_en;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready_o !== 1'b1) @(posedge clk);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    @(posedge clk);
    while (hready_o !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(ad, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    bus(ad, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic moe_is(input logic e);
    bus(OFS_BDTR, 1'b0, 32'h0);
    chk({31'h0, rd[BD_MOE]}, {31'h0, e});
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_upd();
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  function automatic int dt_of(input logic [7:0] g);
    if (!g[7]) return int'(g);
    if (!g[6]) return (64 + int'(g[5:0])) * 2;
    if (!g[5]) return (32 + int'(g[4:0])) * 8;
    return (32 + int'(g[4:0])) * 16;
  endfunction
  // Counts edges from a reference edge until the delayed output rises
  task automatic dt_meas(input logic [7:0] g);
    int n;
    int d;
    d = dt_of(g);
    wr(OFS_BDTR, {16'h0, 8'hB8, g});
    oc_ref <= 1'b0;
    repeat (d + 6) @(posedge clk);
    oc_ref <= 1'b1;
    @(posedge clk);
    n = 1;
    while (ch !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= d + 1 && n <= d + 3}, 32'h1);
    chk({29'h0, chn, ch_oe_n, chn_oe_n}, 32'h0);
    oc_ref <= 1'b0;
    @(posedge clk);
    n = 1;
    while (chn !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= d + 1 && n <= d + 3}, 32'h1);
    chk({31'h0, ch}, 32'h0);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hwdata = 32'h0;
    oc_ref = 1'b0;
    upd = 1'b0;
    capt = 1'b0;
    cval = 16'h0;
    lvl = 1'b0;
    brk = 1'b0;
    void'($urandom(28));
    do_reset();
    foreach (offs[i]) rdc(offs[i], 32'h0);
    wr(8'h80, 32'hFFFF_FFFF);
    rdc(8'h80, 32'h0);
    repeat (4) begin
      a = $urandom();
      wr(OFS_COMPARE_VALUE_CH4, a);
      rdc(OFS_COMPARE_VALUE_CH4, {16'h0, a[15:0]});
    end
    cval <= 16'($urandom());
    lvl <= 1'b1;
    capt <= 1'b1;
    @(posedge clk);
    capt <= 1'b0;
    rdc(OFS_COMPARE_VALUE_CH4, {15'h0, 1'b1, cval});
    wr(OFS_COMPARE_VALUE_CH4, 32'hFFFF_FFFF);
    rdc(OFS_COMPARE_VALUE_CH4, 32'h0001_FFFF);
    wr(OFS_BCFG, 32'hFFFF_FFFF);
    rdc(OFS_BCFG, 32'h0000_1F1F);
    // Two-word burst starting at the channel four word
    wr(OFS_BCFG, 32'h0000_0110);
    a = $urandom();
    wr(OFS_BACC, a);
    wr(OFS_BACC, 32'h0000_0005);
    rdc(OFS_COMPARE_VALUE_CH4, {15'h0, 1'b1, a[15:0]});
    rdc(OFS_BDTR, 32'h0000_0005);
    rdc(OFS_BACC, {15'h0, 1'b1, a[15:0]});
    chk({31'h0, hresp}, 32'h0);
    // Dead time, brake and auto enable; first control write leaves lock off
    do_reset();
    wr(OFS_CHEN, 32'h5);
    wr(OFS_CTRL, 32'h1);
    foreach (tops[i]) dt_meas({tops[i], 5'($urandom())});
    dt_meas(8'hC1);
    brk <= 1'b1;
    @(posedge clk);
    moe_is(1'b0);
    repeat (3) @(posedge clk);
    chk({30'h0, ch_oe_n, chn_oe_n}, 32'h3);
    wr(OFS_BDTR, 32'h0000_B800);
    moe_is(1'b0);
    wr(OFS_BDTR, 32'h0000_2800);
    repeat (4) @(posedge clk);
    wr(OFS_BDTR, 32'h0000_A800);
    moe_is(1'b1);
    wr(OFS_BDTR, 32'h0000_9800);
    repeat (4) @(posedge clk);
    moe_is(1'b1);
    brk <= 1'b0;
    repeat (2) @(posedge clk);
    moe_is(1'b0);
    brk <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OFS_BDTR, 32'h0000_5800);
    pulse_upd();
    moe_is(1'b1);
    wr(OFS_BDTR, 32'h0000_1800);
    pulse_upd();
    moe_is(1'b0);
    wr(OFS_BDTR, 32'h0000_5800);
    wr(OFS_CTRL, 32'h3);
    moe_is(1'b1);
    wr(OFS_CHEN, 32'h1);
    wr(OFS_BDTR, 32'h0000_9800);
    repeat (4) @(posedge clk);
    chk({30'h0, chn, chn_oe_n}, 32'h0);
    wr(OFS_BDTR, 32'h0000_9000);
    repeat (4) @(posedge clk);
    chk({31'h0, chn_oe_n}, 32'h1);
    // The overlap flag is cleared by reset, so look before the next one
    chk({31'h0, shoot}, 32'h0);
    // Idle levels, then lock level three freezes everything it covers
    do_reset();
    wr(OFS_CTRL, 32'h100);
    wr(OFS_CHEN, 32'h5);
    wr(OFS_BDTR, 32'h0000_0F11);
    repeat (4) @(posedge clk);
    chk({28'h0, ch, chn, ch_oe_n, chn_oe_n}, 32'h8);
    chk({30'h0, hi_gate, lo_gate}, 32'h2);
    wr(OFS_BDTR, 32'h0000_7022);
    rdc(OFS_BDTR, 32'h0000_0F11);
    wr(OFS_CHEN, 32'hA);
    rdc(OFS_CHEN, 32'h5);
    wr(OFS_CTRL, 32'h201);
    rdc(OFS_CTRL, 32'h101);
    chk({31'h0, shoot}, 32'h0);
    stop_test();
  end
endmodule

// ### bdl_pkg.sv
// Constants for the brake, dead-time, lock and burst-access block
package bdl_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CHEN    = 8'h20;
  localparam logic [7:0]  OFS_COMPARE_VALUE_CH4    = 8'h40;
  localparam logic [7:0]  OFS_BDTR    = 8'h44;
  localparam logic [7:0]  OFS_BCFG    = 8'h48;
  localparam logic [7:0]  OFS_BACC    = 8'h4C;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int          CTRL_RUN    = 0;
  localparam int          CTRL_UPD    = 1;
  localparam int          CTRL_OIS    = 8;
  localparam int          CTRL_OISN   = 9;
  localparam int          CHEN_CCE    = 0;
  localparam int          CHEN_CCP    = 1;
  localparam int          CHEN_CCNE   = 2;
  localparam int          CHEN_CCNP   = 3;
  localparam int          COMPARE_VALUE_CH4_LVL    = 16;
  localparam int          BD_MOE      = 15;
  localparam int          BD_AOE      = 14;
  localparam int          BD_BKP      = 13;
  localparam int          BD_BKE      = 12;
  localparam int          BD_RUN_OFFSTATE_SELECT     = 11;
  localparam int          BD_IDLE_OFFSTATE_SELECT     = 10;
  localparam int          BD_LOCK     = 8;
  localparam int          BD_DTG      = 0;
  localparam int          BC_LEN      = 8;
  localparam int          BC_BASE     = 0;
  // ****************************************
  // Reset values and lock levels
  // ****************************************
  localparam logic [15:0] COMPARE_VALUE_CH4_RST    = 16'h0000;
  localparam logic [31:0] BACC_RST    = 32'h0000_0000;
  localparam logic [1:0]  LOCK_OFF    = 2'h0;
  localparam logic [1:0]  LOCK_L3     = 2'h3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_NS      = 50;
  localparam int          DTS_NS      = 50;
  localparam int          DTS_CYC     = (DTS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DT_W        = 11;
  localparam logic [1:0]  HTRANS_IDLE = 2'h0;
endpackage

// ### bdl_stage.sv
// Power stage model: gate driver inputs with pull-downs and a shoot-through watch
`timescale 1ns/1ps
module bdl_stage (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Pins from the block
  input  wire logic i_hi,
  input  wire logic i_hi_oe_n,
  input  wire logic i_lo,
  input  wire logic i_lo_oe_n,
  // Gate levels and fault flag
  output logic      o_hi_gate,
  output logic      o_lo_gate,
  output logic      o_shoot
);
  // ****************************************
  // Gate levels
  // ****************************************
  // Released pins fall to the driver's pull-down, never keep the last value
  assign o_hi_gate = (i_hi_oe_n === 1'b0) ? i_hi : 1'b0;
  assign o_lo_gate = (i_lo_oe_n === 1'b0) ? i_lo : 1'b0;
  // Sticky, so a single overlapping cycle is not lost
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_shoot <= 1'b0;
    end else if (o_hi_gate && o_lo_gate) begin
      o_shoot <= 1'b1;
    end
  end
endmodule
